// *** adcc_regs.svh ***
// register offsets, reset values and timing counts of the converter control block
// assumes the includer sits on the 20 MHz system clock
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ADCC_OFF_STATUS 8'h00
`define ADCC_OFF_RESULT 8'h04
`define ADCC_OFF_INT_STAT 8'h08
`define ADCC_OFF_INT_EN 8'h0C
`define ADCC_OFF_INT_CLR 8'h10

// ----------------------------------------
// reset values
// ----------------------------------------
`define ADCC_RST_BYTE 8'h00
`define ADCC_RST_WORD 32'h0000_0000
`define ADCC_RST_CHAN 3'h0
`define ADCC_RST_IRQ 3'h0
`define ADCC_SAR_FIRST 8'h80
`define ADCC_BIT_MSB 3'h7
`define ADCC_BIT_LSB 3'h0
`define ADCC_ONEHOT_BASE 8'h01

// ----------------------------------------
// timing
// ----------------------------------------
`define ADCC_CLK_NS 50
`define ADCC_CONV_NS 1600
`define ADCC_CONV_DIV (`ADCC_CONV_NS / `ADCC_CLK_NS)
`define ADCC_DIV_LAST 5'(`ADCC_CONV_DIV - 1)
`define ADCC_DIV_ZERO 5'h0
// done is sampled high one edge after the period that follows the result load
`define ADCC_LOAD_GAP (`ADCC_CONV_DIV + 1)

`endif

// *** adcc_pkg.sv ***
// types shared by the converter control block
// assumes adcc_regs.svh holds the numbers
`default_nettype none
package adcc_pkg;

  typedef enum logic [2:0] {
    ADCC_IDLE   = 3'b000,
    ADCC_ARMED  = 3'b001,
    ADCC_CONV   = 3'b010,
    ADCC_LOAD   = 3'b011,
    ADCC_FINISH = 3'b100
  } adcc_state_e;

  // sticky event bits, same layout in status, enable and clear registers
  typedef struct packed {
    logic latched;
    logic aborted;
    logic done;
  } adcc_irq_s;

  // status register word
  typedef struct packed {
    logic [23:0] pad;
    logic [2:0] state;
    logic [2:0] chan;
    logic busy;
    logic eoc;
  } adcc_status_s;

endpackage
`default_nettype wire

// *** adcc_sync_edge.sv ***
// two-flop synchroniser with edge pulses for pins from outside the clock domain
// assumes rst_n is already synchronous to clk
`timescale 1ns/1ns
`default_nettype none
module adcc_sync_edge #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_s1;
  logic [W-1:0] next_s2;
  logic [W-1:0] next_s3;

  // shift chain; s1 feeds only s2
  always_comb begin
    next_s1 = d;
    next_s2 = s1;
    next_s3 = s2;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= next_s1;
      s2 <= next_s2;
      s3 <= next_s3;
    end
  end

  // edges look at settled copies only
  assign level = s2;
  assign rise = s2 & ~s3;
  assign fall = ~s2 & s3;
endmodule
`default_nettype wire

// *** adcc_top.sv ***
// control logic of an 8-bit successive-approximation converter with 8-way input select
// assumes an external ladder takes TRIAL_CODE and returns the comparator level on CMP
`timescale 1ns/1ns
`default_nettype none
`include "adcc_regs.svh"

module adcc_top
  import adcc_pkg::*;
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CONVERSION_START_INPUT,
  input wire logic ADDR_STROBE,
  input wire logic [2:0] CHAN_ADDR,
  input wire logic OUT_ENABLE,
  input wire logic CMP,
  output logic EOC,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE,
  output logic [7:0] CHAN_SEL,
  output logic [7:0] TRIAL_CODE,
  output logic IRQ
);

  // ----------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------
  logic rst_q1;
  logic rst_n;
  logic start_rise;
  logic start_fall;
  logic ale_rise;
  logic [2:0] addr_s;
  logic oe_s;
  logic cmp_s;

  // async assert, two-flop release
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // start pin; in free-running use it carries EOC back in
  // loop-back start
  adcc_sync_edge #(.W(1)) u_start (
    .clk(CLK), .rst_n(rst_n), .d(CONVERSION_START_INPUT),
    .level(), .rise(start_rise), .fall(start_fall)
  );

  adcc_sync_edge #(.W(1)) u_ale (
    .clk(CLK), .rst_n(rst_n), .d(ADDR_STROBE),
    .level(), .rise(ale_rise), .fall()
  );

  // address shares the strobe's latency so both are sampled at the same instant
  adcc_sync_edge #(.W(3)) u_addr (
    .clk(CLK), .rst_n(rst_n), .d(CHAN_ADDR),
    .level(addr_s), .rise(), .fall()
  );

  adcc_sync_edge #(.W(1)) u_oe (
    .clk(CLK), .rst_n(rst_n), .d(OUT_ENABLE),
    .level(oe_s), .rise(), .fall()
  );

  adcc_sync_edge #(.W(1)) u_cmp (
    .clk(CLK), .rst_n(rst_n), .d(CMP),
    .level(cmp_s), .rise(), .fall()
  );

  // ----------------------------------------
  // conversion clock and channel latch
  // ----------------------------------------
  logic [4:0] div_cnt;
  logic [4:0] next_div_cnt;
  logic tick;
  logic [2:0] chan;
  logic [2:0] next_chan;
  logic [7:0] next_chan_sel;
  logic conv_go;

  assign tick = (div_cnt == `ADCC_DIV_LAST);

  // divider realigns when a conversion begins, so the first bit decision sees a settled comparator
  always_comb begin
    next_div_cnt = (tick || conv_go) ? `ADCC_DIV_ZERO : div_cnt + 5'h1;
    next_chan = chan;
    if (ale_rise) begin
      next_chan = addr_s;
    end
    next_chan_sel = `ADCC_ONEHOT_BASE << chan;
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= `ADCC_DIV_ZERO;
      chan <= `ADCC_RST_CHAN;
      CHAN_SEL <= `ADCC_ONEHOT_BASE;
    end else begin
      div_cnt <= next_div_cnt;
      chan <= next_chan;
      CHAN_SEL <= next_chan_sel;
    end
  end

  // ----------------------------------------
  // approximation sequencer
  // ----------------------------------------
  adcc_state_e state;
  adcc_state_e next_state;
  logic [7:0] sar;
  logic [7:0] next_sar;
  logic [2:0] bit_idx;
  logic [2:0] next_bit_idx;
  logic [7:0] result;
  logic [7:0] next_result;
  logic next_eoc;
  logic busy;
  logic load_pulse;
  logic abort_evt;
  logic done_evt;

  assign busy = (state != ADCC_IDLE);
  assign load_pulse = (state == ADCC_LOAD) && tick && !start_rise;
  assign abort_evt = start_rise && busy;
  assign done_evt = (state == ADCC_FINISH) && tick && !start_rise;
  assign conv_go = (state == ADCC_ARMED) && start_fall && !start_rise;

  // start rise overrides every state, so a restart needs no special path
  always_comb begin
    next_state = state;
    next_sar = sar;
    next_bit_idx = bit_idx;
    next_result = result;
    next_eoc = EOC;
    if (start_rise) begin
      next_sar = `ADCC_RST_BYTE;
      next_state = ADCC_ARMED;
      next_eoc = 1'b0;
    end else begin
      case (state)
        ADCC_IDLE: begin
          next_eoc = 1'b1;
        end
        ADCC_ARMED: begin
          if (start_fall) begin
            next_sar = `ADCC_SAR_FIRST;
            next_bit_idx = `ADCC_BIT_MSB;
            next_state = ADCC_CONV;
          end
        end
        ADCC_CONV: begin
          if (tick) begin
            next_sar[bit_idx] = cmp_s;
            if (bit_idx == `ADCC_BIT_LSB) begin
              next_state = ADCC_LOAD;
            end else begin
              next_sar[bit_idx - 3'h1] = 1'b1;
              next_bit_idx = bit_idx - 3'h1;
            end
          end
        end
        ADCC_LOAD: begin
          if (tick) begin
            next_result = sar;
            next_state = ADCC_FINISH;
          end
        end
        ADCC_FINISH: begin
          if (tick) begin
            next_eoc = 1'b1;
            next_state = ADCC_IDLE;
          end
        end
        default: begin
          next_state = ADCC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state <= ADCC_IDLE;
      sar <= `ADCC_RST_BYTE;
      bit_idx <= `ADCC_BIT_MSB;
      result <= `ADCC_RST_BYTE;
      EOC <= 1'b1;
      TRIAL_CODE <= `ADCC_RST_BYTE;
      DATA_OUT <= `ADCC_RST_BYTE;
      DATA_OE <= 1'b0;
    end else begin
      state <= next_state;
      sar <= next_sar;
      bit_idx <= next_bit_idx;
      result <= next_result;
      EOC <= next_eoc;
      TRIAL_CODE <= next_sar;
      DATA_OUT <= next_result;
      DATA_OE <= oe_s;
    end
  end

  // ----------------------------------------
  // apb slave and interrupt registers
  // ----------------------------------------
  adcc_irq_s int_stat;
  adcc_irq_s next_int_stat;
  adcc_irq_s int_en;
  adcc_irq_s next_int_en;
  adcc_irq_s int_set;
  adcc_irq_s int_clr;
  adcc_status_s status;
  logic access;
  logic wr_fire;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] next_prdata;
  logic next_irq;

  assign access = PSEL && PENABLE && !PREADY;
  assign wr_fire = PSEL && PENABLE && PREADY && PWRITE;

  // one wait state keeps read data registered
  always_comb begin
    status = '{pad: '0, state: state, chan: chan, busy: busy, eoc: EOC};
    int_set = '{latched: ale_rise, aborted: abort_evt, done: done_evt};
    int_clr = '0;
    next_int_en = int_en;
    if (wr_fire && PADDR == `ADCC_OFF_INT_CLR) begin
      int_clr = PWDATA[$bits(adcc_irq_s)-1:0];
    end
    if (wr_fire && PADDR == `ADCC_OFF_INT_EN) begin
      next_int_en = PWDATA[$bits(adcc_irq_s)-1:0];
    end
    // set beats clear in the same cycle
    next_int_stat = (int_stat & ~int_clr) | int_set;
    next_irq = |(next_int_stat & next_int_en);
    next_pready = access;
    next_pslverr = 1'b0;
    next_prdata = `ADCC_RST_WORD;
    if (access) begin
      case (PADDR)
        `ADCC_OFF_STATUS: next_prdata = status;
        `ADCC_OFF_RESULT: next_prdata = {24'h00_0000, result};
        `ADCC_OFF_INT_STAT: next_prdata = {29'h0000_0000, int_stat};
        `ADCC_OFF_INT_EN: next_prdata = {29'h0000_0000, int_en};
        `ADCC_OFF_INT_CLR: next_prdata = `ADCC_RST_WORD;
        default: next_pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      int_stat <= `ADCC_RST_IRQ;
      int_en <= `ADCC_RST_IRQ;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= `ADCC_RST_WORD;
      IRQ <= 1'b0;
    end else begin
      int_stat <= next_int_stat;
      int_en <= next_int_en;
      PREADY <= next_pready;
      PSLVERR <= next_pslverr;
      PRDATA <= next_prdata;
      IRQ <= next_irq;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  localparam int load_gap = `ADCC_LOAD_GAP;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!rst_n);

  sequence s_restart;
    start_rise ##1 (state == ADCC_ARMED);
  endsequence

  sequence s_begin;
    (state == ADCC_ARMED) && start_fall && !start_rise;
  endsequence

  a_addr_latch: assert property (ale_rise |=> chan == $past(addr_s))
    else $error("channel not latched on strobe");
  a_chan_hold: assert property (!ale_rise |=> $stable(chan))
    else $error("channel changed without strobe");
  a_chan_decode: assert property (1'b1 |=> CHAN_SEL == (`ADCC_ONEHOT_BASE << $past(chan)))
    else $error("channel decode wrong");
  a_sar_clear: assert property (start_rise |=> sar == `ADCC_RST_BYTE)
    else $error("register not cleared on start");
  a_begin_fall: assert property (s_begin |=> state == ADCC_CONV && sar == `ADCC_SAR_FIRST)
    else $error("conversion did not begin on fall");
  a_no_rise_go: assert property ((state == ADCC_ARMED) && !start_fall |=> state != ADCC_CONV)
    else $error("conversion began without fall");
  a_restart_seq: assert property (abort_evt |-> s_restart)
    else $error("restart not taken");
  a_eoc_low: assert property (start_rise |=> !EOC [*2])
    else $error("done not low after start");
  a_load_ahead: assert property ($rose(EOC) |-> $past(load_pulse, load_gap))
    else $error("result not loaded one period before done");
  a_bit_step: assert property ((state == ADCC_CONV) && tick && !start_rise && bit_idx != `ADCC_BIT_LSB
    |=> bit_idx == $past(bit_idx) - 3'h1)
    else $error("bit index did not step");
  a_bit_value: assert property ((state == ADCC_CONV) && tick && !start_rise
    |=> sar[$past(bit_idx)] == $past(cmp_s))
    else $error("bit does not follow comparator");
  a_oe_follow: assert property (1'b1 |=> DATA_OE == $past(oe_s))
    else $error("output enable mismatch");
  a_eoc_busy: assert property (busy && !(state == ADCC_FINISH) |=> !EOC || $past(state) == ADCC_FINISH)
    else $error("done high during conversion");
  a_irq_level: assert property (1'b1 |=> IRQ == |($past(next_int_stat) & $past(next_int_en)))
    else $error("interrupt level wrong");

endmodule
`default_nettype wire

// *** adcc_front_model.sv ***
// far-side model: per-channel input levels, comparator and start wiring
// assumes the bench sets the levels and drives the start request
`timescale 1ns/1ns
`default_nettype none
module adcc_front_model (
  input wire logic clk,
  input wire logic [7:0][7:0] level,
  input wire logic [7:0] chan_sel,
  input wire logic [7:0] trial_code,
  input wire logic eoc,
  input wire logic loop_on,
  input wire logic start_req,
  output logic cmp,
  output logic start
);
  // --------
  // comparator
  // --------
  // strobed once a clock, as a chopper stage would be
  always_ff @(posedge clk) begin
    cmp <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (chan_sel[i]) begin
        cmp <= level[i] >= trial_code;
      end
    end
  end
  // --------
  // start pin
  // --------
  // done fed back
  assign start = start_req | (loop_on & eoc);
endmodule
`default_nettype wire

// *** eight_channel_sar_adc_control_tb.sv ***
// self-checking bench: channel select, conversions, output enable, apb and irq
// assumes adcc_top and adcc_front_model are compiled first
`timescale 1ns/1ns
`default_nettype none
`include "adcc_regs.svh"
module eight_channel_sar_adc_control_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic start_req = 1'b0;
  logic loop_on = 1'b0;
  logic ale = 1'b0;
  logic oe = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0][7:0] lvl = 64'h0000_0000_0000_0000;
  logic [31:0] prdata;
  logic [31:0] rq;
  logic re;
  logic pready;
  logic pslverr;
  logic cmp;
  logic start;
  logic eoc;
  logic [7:0] dout;
  logic doe;
  logic [7:0] csel;
  logic [7:0] trial;
  logic irq;
  int errors = 0;
  int checks = 0;
  int cyc = 0;
  // resolved data bus, floats while the block does not drive it
  wire logic [7:0] bus = doe ? dout : 8'hzz;
  // --------
  // design and far side
  // --------
  adcc_top dut_u (
    .CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CONVERSION_START_INPUT(start), .ADDR_STROBE(ale), .CHAN_ADDR(addr), .OUT_ENABLE(oe), .CMP(cmp),
    .EOC(eoc), .DATA_OUT(dout), .DATA_OE(doe), .CHAN_SEL(csel), .TRIAL_CODE(trial), .IRQ(irq)
  );
  adcc_front_model model_u (
    .clk(clk), .level(lvl), .chan_sel(csel), .trial_code(trial), .eoc(eoc), .loop_on(loop_on),
    .start_req(start_req), .cmp(cmp), .start(start)
  );
  // 20 MHz clock
  initial begin
    forever #25 clk = ~clk;
  end
  // hang guard, well above the ~4200 cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      wrap_up;
    end
  end
  // --------
  // shared tasks
  // --------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one apb transfer; result left in rq and re
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the hang guard ends this wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_eoc(input logic v, input int lim, output int n);
    n = 0;
    while (eoc !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  // address held well around the strobe, pins are synchronised
  task automatic sel(input logic [2:0] ch);
    addr <= ch;
    repeat (3) @(posedge clk);
    ale <= 1'b1;
    repeat (4) @(posedge clk);
    ale <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  // start held high long enough to show nothing begins yet
  task automatic pulse(output int n);
    start_req <= 1'b1;
    wait_eoc(1'b0, 400, n);
    repeat (10) @(posedge clk);
    chk("sar_clear", 8'h00, trial);
    start_req <= 1'b0;
  endtask
  task automatic convert(input logic [2:0] ch, input logic [7:0] v, input int cut, input logic [7:0] v2);
    int n;
    int t_load;
    logic [7:0] prev;
    lvl[ch] <= v;
    pulse(n);
    chk("eoc_fall", 1'h1, n <= 8 * `ADCC_CONV_DIV);
    if (cut > 0) begin
      repeat (cut) @(posedge clk);
      chk("eoc_mid", 1'h0, eoc);
      lvl[ch] <= v2;
      pulse(n);
      chk("eoc_restart", 1'h0, eoc);
    end
    prev = dout;
    n = 0;
    t_load = -1;
    while (eoc !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
      if (dout !== prev && t_load < 0) begin
        t_load = n;
      end
    end
    chk("load_lead", `ADCC_CONV_DIV, 32'(n - t_load));
    chk("result", (cut > 0) ? v2 : v, dout);
  endtask
  // --------
  // scenarios
  // --------
  task automatic t_reset;
    chk("eoc_idle", 1'h1, eoc);
    chk("sel_reset", 8'h01, csel);
    chk("irq_reset", 1'h0, irq);
    apb(1'b0, `ADCC_OFF_INT_STAT, 32'h0000_0000);
    chk("stat_reset", 32'h0000_0000, rq);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("bad_addr_err", 1'h1, re);
    chk("bad_addr_data", 32'h0000_0000, rq);
  endtask
  task automatic t_chan;
    for (int i = 0; i < 8; i++) begin
      sel(3'(i));
      chk("chan_sel", 8'h01 << i, csel);
    end
    addr <= 3'h2;
    repeat (8) @(posedge clk);
    chk("chan_hold", 8'h80, csel);
  endtask
  // boundary codes, each differs from the one before
  task automatic t_conv;
    logic [7:0] v [5];
    v = '{8'hA5, 8'hFF, 8'h01, 8'h80, 8'h00};
    for (int i = 0; i < 5; i++) begin
      sel(3'(i + 3));
      convert(3'(i + 3), v[i], 0, 8'h00);
    end
  endtask
  task automatic t_abort;
    sel(3'h2);
    convert(3'h2, 8'hC3, 100, 8'h3C);
    apb(1'b0, `ADCC_OFF_INT_STAT, 32'h0000_0000);
    chk("stat_abort", 1'h1, rq[1]);
  endtask
  task automatic t_oe;
    oe <= 1'b0;
    repeat (6) @(posedge clk);
    chk("bus_off", 32'h0000_00zz, bus);
    oe <= 1'b1;
    repeat (6) @(posedge clk);
    chk("bus_on", 8'h3C, bus);
    oe <= 1'b0;
  endtask
  task automatic t_irq;
    apb(1'b1, `ADCC_OFF_INT_CLR, 32'h0000_0007);
    apb(1'b1, `ADCC_OFF_INT_EN, 32'h0000_0001);
    apb(1'b0, `ADCC_OFF_INT_EN, 32'h0000_0000);
    chk("int_en", 32'h0000_0001, rq);
    sel(3'h1);
    convert(3'h1, 8'h77, 0, 8'h00);
    repeat (4) @(posedge clk);
    chk("irq_set", 1'h1, irq);
    apb(1'b0, `ADCC_OFF_RESULT, 32'h0000_0000);
    chk("result_reg", 32'h0000_0077, rq);
    apb(1'b0, `ADCC_OFF_STATUS, 32'h0000_0000);
    chk("status_eoc", 1'h1, rq[0]);
    apb(1'b1, `ADCC_OFF_INT_CLR, 32'h0000_0001);
    repeat (4) @(posedge clk);
    chk("irq_clear", 1'h0, irq);
    apb(1'b1, `ADCC_OFF_INT_EN, 32'h0000_0000);
    convert(3'h1, 8'h11, 0, 8'h00);
    repeat (4) @(posedge clk);
    chk("irq_masked", 1'h0, irq);
    apb(1'b0, `ADCC_OFF_INT_STAT, 32'h0000_0000);
    chk("stat_done", 1'h1, rq[0]);
  endtask
  // done looped back to start, one outside pulse to get going
  task automatic t_free;
    int n;
    sel(3'h4);
    lvl[4] <= 8'h5A;
    loop_on <= 1'b1;
    pulse(n);
    repeat (2) begin
      wait_eoc(1'b1, 1000, n);
      chk("free_result", 8'h5A, dout);
      wait_eoc(1'b0, 50, n);
      chk("free_restart", 1'h0, eoc);
    end
    loop_on <= 1'b0;
    wait_eoc(1'b1, 1000, n);
    // no loop-back now, so done must stay high
    repeat (40) @(posedge clk);
    chk("free_stop", 1'h1, eoc);
  endtask
  task automatic wrap_up;
    if (errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // --------
  // main sequence
  // --------
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_chan;
    t_conv;
    t_abort;
    t_oe;
    t_irq;
    t_free;
    wrap_up;
  end
endmodule
`default_nettype wire
